// file: hw/cpm_top.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Function
// R1: main multiplier input divided by programmable n from 1 to 256
// R2: multiplier factor m 1..32768 by dividing oscillator and comparing
// R3: software keeps oscillator between 275 and 550 MHz
// R4: main multiplier off and bypassed after reset and in power-down
// R5: software enables, waits for lock, then connects multiplier
// R6: usb multiplier fed from main oscillator only, 48 MHz to usb
// R7: usb multiplier off at reset; usb clock from main otherwise
// R8: usb multiplier output has 50 percent duty
// R9: clock out selects cpu, rc, main, rtc or usb clock
// R10: run from internal rc after power-up and power-down wake
// R11: power-down wake always passes through wake-up timer
// R12: sleep stops core clock only; resume on reset or interrupt; here sleep also removes rc and flash power
// R13: deep-sleep stops clocks, rc gated but powered, rtc runs
// R14: deep-sleep entry disconnects multiplier, clears cpu/usb dividers
// R15: deep-sleep ends on reset or clockless interrupt; flash stays on
// R16: deep-sleep wake resumes after 4 rc or 4096 oscillator cycles
// R17: power-down also removes rc and flash power
// R18: power-down wake waits 60 us rc start plus 4 rc cycles
// R19: flash counter blocks flash for 100 us of rc cycles
// R20: deep power-down only via rtc; wake by reset pin or alarm
// R21: collector latches interrupt mask at entry, wakes on match
// R22: software reconfigures multiplier and dividers after wake
// R23: readable lock indication for the main multiplier
module cpm_top
(
    // clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_srst,
    // apb slave
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [7:0]           i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    // interrupt controller, rtc and oscillator
    input  wire logic [31:0]          i_irq_enabled,
    input  wire logic [31:0]          i_irq_pending,
    input  wire logic                 i_rtc_dpd_req,
    input  wire logic                 i_rtc_alarm,
    input  wire logic                 i_osc_ref_tick,
    // clock and power controls
    output logic                      o_core_clk_en,
    output logic                      o_periph_clk_en,
    output logic                      o_rc_out_en,
    output logic                      o_rc_power,
    output logic                      o_flash_power,
    output logic                      o_flash_ready,
    output logic                      o_mul_power,
    output logic                      o_mul_connect,
    output logic                      o_usb_mul_power,
    output logic                      o_usb_clk_from_usb_mul,
    output logic                      o_usb_clk,
    output cpm_pkg::cpm_src_type      o_src_sel,
    output cpm_pkg::cpm_out_type      o_clkout_sel,
    output logic      [7:0]           o_cpu_div,
    output logic      [7:0]           o_usb_div,
    output logic                      o_rtc_keep,
    output logic                      o_chip_power
);
    import cpm_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN, ST_LOW, ST_RC_START, ST_RC_WAIT, ST_OSC_WAIT
    } cpm_seq_type;

    cpm_seq_type  seq;
    cpm_mode_type mode;
    logic [31:0]  ctrl;
    logic [31:0]  div;
    logic [31:0]  clkdiv;
    logic [31:0]  wake_mask;
    logic         locked;
    logic [7:0]   lock_cnt;
    logic         cnt_load;
    logic [15:0]  cnt_value;
    logic         cnt_done;
    logic         fl_load;
    logic         fl_done;
    logic         osc_used;
    logic         wake_hit;
    logic         fb_tick;
    logic         ref_tick;
    logic [1:0]   usb_ph;
    logic         wr_en;
    logic         rd_en;

    // cycles as function of a count of rc periods
    function automatic logic [15:0] rc_cycles(input int n);
        rc_cycles = 16'(n * CYC_PER_RC);
    endfunction : rc_cycles

    assign wr_en    = i_psel && i_penable && i_pwrite;
    assign rd_en    = i_psel && !i_penable && !i_pwrite;
    assign wake_hit = |(wake_mask & i_irq_pending);

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    // control register; hardware clears on reset, and clears multiplier and source bits on entry to modes other than sleep
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            ctrl   <= 32'h0000_0000; // see R4 see R7 see R10
            div    <= 32'h0000_0000;
            clkdiv <= RST_DIV;
        end
        else if (seq == ST_RUN && mode != PM_RUN && mode != PM_SLEEP)
        begin
            // multiplier off, disconnected, rc selected
            ctrl[CTRL_MUL_EN]   <= 1'b0; // see R14 see R4
            ctrl[CTRL_MUL_CONN] <= 1'b0; // see R14
            ctrl[CTRL_SRC_LO +: 2] <= 2'(SRC_RC); // see R10
            clkdiv <= RST_DIV; // see R14
        end
        else if (wr_en && o_pready)
        begin
            case (i_paddr)
                ADDR_CTRL:
                begin
                    ctrl <= i_pwdata;
                    // connect only takes once locked
                    ctrl[CTRL_MUL_CONN] <= i_pwdata[CTRL_MUL_CONN]
                        && locked && i_pwdata[CTRL_MUL_EN]; // see R5
                end
                ADDR_DIV:    div    <= i_pwdata;
                ADDR_CLKDIV: clkdiv <= i_pwdata;
                default:     ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // main multiplier model: n and m dividers, lock detect
    // ---------------------------------------------------------------
    cpm_divider u_ref_div
    (
        .i_mclk     (i_mclk),
        .i_srst     (i_srst || !ctrl[CTRL_MUL_EN]),
        .i_en       (i_osc_ref_tick), // counts reference edges only
        .i_ratio_m1 ({7'h00, div[DIV_N_LO +: 8]}), // see R1
        .o_tick     (ref_tick)
    );

    cpm_divider u_fb_div
    (
        .i_mclk     (i_mclk),
        .i_srst     (i_srst || !ctrl[CTRL_MUL_EN]),
        .i_en       (ctrl[CTRL_MUL_EN]),
        .i_ratio_m1 (div[DIV_M_LO +: 15]), // see R2
        .o_tick     (fb_tick)
    );

    // lock after a run of phase compare events
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || !ctrl[CTRL_MUL_EN])
        begin
            lock_cnt <= 8'h00;
            locked   <= 1'b0;
        end
        else if (ref_tick || fb_tick)
        begin
            if (lock_cnt == 8'(LOCK_CYC))
                locked <= 1'b1; // see R23
            else
                lock_cnt <= lock_cnt + 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // power mode sequencer
    // ---------------------------------------------------------------
    cpm_counter u_wake_cnt
    (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_load  (cnt_load),
        .i_value (cnt_value),
        .o_done  (cnt_done)
    );

    cpm_counter u_flash_cnt
    (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_load  (fl_load),
        .i_value (rc_cycles(FLASH_RC_CYC)), // see R19
        .o_done  (fl_done)
    );

    // sequencer: mode entry, wait for wake, wake timers
    always_ff @(posedge i_mclk)
    begin
        cnt_load  <= 1'b0;
        fl_load   <= 1'b0;
        if (i_srst)
        begin
            seq       <= ST_RUN;
            mode      <= PM_RUN;
            wake_mask <= 32'h0000_0000;
            osc_used  <= 1'b0;
            cnt_value <= 16'h0000;
        end
        else
        begin
            case (seq)
                ST_RUN:
                begin
                    if (i_rtc_dpd_req)
                        mode <= PM_DEEP_PD; // see R20
                    else if (wr_en && o_pready && i_paddr == ADDR_PMODE
                             && i_pwdata[2:0] < 3'(PM_DEEP_PD))
                        mode <= cpm_mode_type'(i_pwdata[2:0]);
                    if (mode != PM_RUN)
                    begin
                        // latch enabled interrupts at entry
                        wake_mask <= i_irq_enabled; // see R21
                        osc_used  <= ctrl[CTRL_SRC_LO +: 2] != 2'(SRC_RC);
                        seq       <= ST_LOW;
                    end
                end
                ST_LOW:
                begin
                    if (mode == PM_DEEP_PD ? i_rtc_alarm : wake_hit)
                    begin // see R12 see R15 see R20
                        if (mode == PM_POWER_DOWN)
                        begin
                            cnt_load  <= 1'b1; // see R11 see R18
                            cnt_value <= 16'(RC_START_CYC);
                            seq       <= ST_RC_START;
                        end
                        else if (mode == PM_DEEP_SLEEP)
                        begin
                            cnt_load  <= 1'b1; // see R16
                            cnt_value <= osc_used ? 16'(WAKE_OSC_CYC)
                                                  : rc_cycles(WAKE_RC_CYC);
                            seq       <= osc_used ? ST_OSC_WAIT : ST_RC_WAIT;
                        end
                        else
                        begin
                            mode <= PM_RUN;
                            seq  <= ST_RUN;
                        end
                    end
                end
                ST_RC_START:
                begin
                    if (cnt_done)
                    begin
                        cnt_load  <= 1'b1;
                        fl_load   <= 1'b1; // see R19
                        cnt_value <= rc_cycles(WAKE_RC_CYC); // see R18
                        seq       <= ST_RC_WAIT;
                    end
                end
                ST_RC_WAIT, ST_OSC_WAIT:
                begin
                    if (cnt_done)
                    begin
                        mode <= PM_RUN;
                        seq  <= ST_RUN;
                    end
                end
                default: seq <= ST_RUN;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // usb 48 MHz model: even phase counter for 50 percent duty
    // ---------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || !ctrl[CTRL_USB_EN])
        begin
            usb_ph    <= 2'h0;
            o_usb_clk <= 1'b0;
        end
        else if (usb_ph == 2'(USB_HALF - 1))
        begin
            usb_ph    <= 2'h0;
            o_usb_clk <= !o_usb_clk; // see R8 see R6
        end
        else
            usb_ph <= usb_ph + 2'h1;
    end

    // ---------------------------------------------------------------
    // registered power and clock controls
    // ---------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_core_clk_en   <= 1'b1;
            o_periph_clk_en <= 1'b1;
            o_rc_out_en     <= 1'b1;
            o_rc_power      <= 1'b1;
            o_flash_power   <= 1'b1;
            o_flash_ready   <= 1'b1;
            o_mul_power     <= 1'b0;
            o_mul_connect   <= 1'b0;
            o_usb_mul_power <= 1'b0;
            o_usb_clk_from_usb_mul <= 1'b0;
            o_src_sel       <= SRC_RC;
            o_clkout_sel    <= OUT_CPU;
            o_cpu_div       <= 8'h00;
            o_usb_div       <= 8'h00;
            o_rtc_keep      <= 1'b1;
            o_chip_power    <= 1'b1;
        end
        else
        begin
            o_core_clk_en   <= seq == ST_RUN && mode == PM_RUN; // see R12
            o_periph_clk_en <= mode == PM_RUN || mode == PM_SLEEP; // see R12
            o_rc_out_en     <= !(seq == ST_LOW && mode != PM_SLEEP); // see R13
            o_rc_power      <= !(seq == ST_LOW && mode != PM_DEEP_SLEEP);
            o_flash_power   <= !(seq == ST_LOW && mode != PM_DEEP_SLEEP)
                               ; // see R15 see R17
            o_flash_ready   <= fl_done && seq != ST_RC_START
                               && !(seq == ST_LOW && mode != PM_DEEP_SLEEP);
            o_mul_power     <= ctrl[CTRL_MUL_EN]; // see R4
            o_mul_connect   <= ctrl[CTRL_MUL_CONN] && locked;
            o_usb_mul_power <= ctrl[CTRL_USB_EN]; // see R7
            o_usb_clk_from_usb_mul <= ctrl[CTRL_USB_EN];
            o_src_sel       <= cpm_src_type'(ctrl[CTRL_SRC_LO +: 2]);
            o_clkout_sel    <= cpm_out_type'(ctrl[CTRL_OUT_LO +: 3]); // see R9
            o_cpu_div       <= clkdiv[7:0];
            o_usb_div       <= clkdiv[15:8];
            o_rtc_keep      <= 1'b1; // see R13
            o_chip_power    <= !(seq == ST_LOW && mode == PM_DEEP_PD);
        end
    end

    // ---------------------------------------------------------------
    // apb read path, one wait state
    // ---------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready  <= i_psel && !o_pready && i_penable;
            o_pslverr <= i_psel && i_penable && !o_pready
                && i_paddr > ADDR_WAKEMSK;
            if (rd_en)
            begin
                case (i_paddr)
                    ADDR_CTRL:    o_prdata <= ctrl;
                    ADDR_DIV:     o_prdata <= div;
                    ADDR_CLKDIV:  o_prdata <= clkdiv;
                    ADDR_PMODE:   o_prdata <= {29'h0, mode};
                    ADDR_STATUS:  o_prdata <= {25'h0, mode, 2'h0,
                                               o_flash_ready, locked};
                    ADDR_WAKEMSK: o_prdata <= wake_mask;
                    default:      o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_connect_needs_lock;
        @(posedge i_mclk) disable iff (i_srst)
        o_mul_connect |-> $past(locked);
    endproperty
    a_connect_needs_lock: assert property (p_connect_needs_lock) // see R5
        else $error("multiplier connected without lock");

    property p_sleep_core_off;
        @(posedge i_mclk) disable iff (i_srst)
        (seq == ST_LOW && mode == PM_SLEEP) |=> !o_core_clk_en;
    endproperty
    a_sleep_core_off: assert property (p_sleep_core_off) // see R12
        else $error("core clock running in sleep");

    property p_deep_clears_mul;
        @(posedge i_mclk) disable iff (i_srst)
        (seq == ST_LOW && mode == PM_DEEP_SLEEP) |-> !ctrl[CTRL_MUL_EN];
    endproperty
    a_deep_clears_mul: assert property (p_deep_clears_mul) // see R14
        else $error("multiplier left on in deep-sleep");

    property p_ds_flash_on;
        @(posedge i_mclk) disable iff (i_srst)
        (seq == ST_LOW && mode == PM_DEEP_SLEEP) |=> o_flash_power;
    endproperty
    a_ds_flash_on: assert property (p_ds_flash_on) // see R15
        else $error("flash off in deep-sleep");

    property p_pd_flash_off;
        @(posedge i_mclk) disable iff (i_srst)
        (seq == ST_LOW && mode == PM_POWER_DOWN) |=> !o_flash_power
            && !o_rc_power;
    endproperty
    a_pd_flash_off: assert property (p_pd_flash_off) // see R17
        else $error("rc or flash powered in power-down");

    property p_rc_wake_time;
        @(posedge i_mclk) disable iff (i_srst)
        (seq == ST_LOW && mode == PM_DEEP_SLEEP && wake_hit && !osc_used)
            |=> seq == ST_RC_WAIT ##129 seq == ST_RC_WAIT ##1 seq == ST_RUN;
    endproperty
    a_rc_wake_time: assert property (p_rc_wake_time) // see R16
        else $error("deep-sleep rc wake time wrong");

    property p_wake_via_timer;
        @(posedge i_mclk) disable iff (i_srst)
        (seq == ST_LOW && mode == PM_POWER_DOWN && wake_hit)
            |=> seq == ST_RC_START;
    endproperty
    a_wake_via_timer: assert property (p_wake_via_timer) // see R11
        else $error("power-down wake skipped timer");

    property p_mask_latched;
        @(posedge i_mclk) disable iff (i_srst)
        (seq == ST_RUN && mode != PM_RUN)
            |=> wake_mask == $past(i_irq_enabled);
    endproperty
    a_mask_latched: assert property (p_mask_latched) // see R21
        else $error("wake mask not captured");

    c_sleep_wake: cover property (@(posedge i_mclk) disable iff (i_srst)
        seq == ST_LOW && mode == PM_SLEEP ##1 seq == ST_RUN);
    c_pd_wake: cover property (@(posedge i_mclk) disable iff (i_srst)
        seq == ST_RC_WAIT && mode == PM_POWER_DOWN);
    c_lock: cover property (@(posedge i_mclk) disable iff (i_srst)
        o_mul_connect);
endmodule : cpm_top
`default_nettype wire

// file: hw/cpm_pkg.sv
package cpm_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00; // enables, connect, selects
    localparam logic [7:0] ADDR_DIV     = 8'h04; // n-1 and m-1 settings
    localparam logic [7:0] ADDR_CLKDIV  = 8'h08; // cpu / usb dividers
    localparam logic [7:0] ADDR_PMODE   = 8'h0C; // power mode request
    localparam logic [7:0] ADDR_STATUS  = 8'h10; // lock, mode, flash ready
    localparam logic [7:0] ADDR_WAKEMSK = 8'h14; // collector mask view

    // ctrl fields
    localparam int CTRL_MUL_EN    = 0;
    localparam int CTRL_MUL_CONN  = 1;
    localparam int CTRL_USB_EN    = 2;
    localparam int CTRL_SRC_LO    = 4; // 2-bit source select
    localparam int CTRL_OUT_LO    = 8; // 3-bit clock out select
    // div fields
    localparam int DIV_M_LO       = 0;  // 15 bits, m-1
    localparam int DIV_N_LO       = 16; // 8 bits, n-1
    // status fields
    localparam int ST_LOCK        = 0;
    localparam int ST_FLASH_RDY   = 1;
    localparam int ST_MODE_LO     = 4;

    // ---------------------------------------------------------------
    // enumerations
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_RC, SRC_MAIN_OSC, SRC_RTC
    } cpm_src_type;

    typedef enum logic [2:0] {
        OUT_CPU, OUT_RC, OUT_MAIN, OUT_RTC, OUT_USB
    } cpm_out_type;

    typedef enum logic [2:0] {
        PM_RUN, PM_SLEEP, PM_DEEP_SLEEP, PM_POWER_DOWN, PM_DEEP_PD
    } cpm_mode_type;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ         = 125;
    localparam int RC_MHZ          = 4;
    localparam int CYC_PER_RC      = (CLK_MHZ + RC_MHZ - 1) / RC_MHZ;
    localparam int WAKE_RC_CYC     = 4;    // deep-sleep wake, rc in use
    localparam int WAKE_OSC_CYC    = 4096; // deep-sleep wake, oscillator
    localparam int RC_START_US     = 60;
    localparam int RC_START_CYC    = RC_START_US * CLK_MHZ;
    localparam int FLASH_START_US  = 100;
    localparam int FLASH_RC_CYC    = FLASH_START_US * RC_MHZ;
    localparam int LOCK_CYC        = 64;   // lock settle time
    localparam int USB_HALF        = 2;    // half period for 48 MHz model
    localparam logic [31:0] RST_DIV = 32'h0000_0000;
endpackage : cpm_pkg

// file: hw/cpm_counter.sv
`timescale 1ns/10ps
`default_nettype none
// loadable down counter with done flag
module cpm_counter
(
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_srst,
    // control
    input  wire logic        i_load,
    input  wire logic [15:0] i_value,
    // status
    output logic             o_done
);
    logic [15:0] count;

    // count down to zero after a load
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            count <= 16'h0000;
        else if (i_load)
            count <= i_value;
        else if (count != 16'h0000)
            count <= count - 16'h0001;
    end

    assign o_done = (count == 16'h0000) && !i_load;
endmodule : cpm_counter
`default_nettype wire

// file: hw/cpm_divider.sv
`timescale 1ns/10ps
`default_nettype none
// divide-by-ratio pulse generator used for pll compare legs
module cpm_divider
(
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_srst,
    // settings
    input  wire logic        i_en,
    input  wire logic [14:0] i_ratio_m1,
    // output
    output logic             o_tick
);
    logic [14:0] count;

    // wrap at ratio, tick on wrap; count holds while not enabled
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            count  <= 15'h0000;
            o_tick <= 1'b0;
        end
        else if (!i_en)
            o_tick <= 1'b0;
        else if (count >= i_ratio_m1)
        begin
            count  <= 15'h0000;
            o_tick <= 1'b1;
        end
        else
        begin
            count  <= count + 15'h0001;
            o_tick <= 1'b0;
        end
    end
endmodule : cpm_divider
`default_nettype wire

// file: verification/cpm_far_side.sv
`timescale 1ns/10ps
`default_nettype none
// interrupt controller, rtc and oscillator seen from the block
module cpm_far_side
(
    // clock
    input  wire logic        i_mclk,
    // commands from the bench
    input  wire logic [1:0]  i_raise,
    input  wire logic        i_dpd,
    input  wire logic        i_alarm,
    // towards the block
    output logic      [31:0] o_irq_enabled,
    output logic      [31:0] o_irq_pending,
    output logic             o_rtc_dpd_req,
    output logic             o_rtc_alarm,
    output logic             o_osc_ref_tick
);
    logic [1:0] tick_cnt = 2'h0;
    // line 3 enabled, line 7 masked off
    assign o_irq_enabled = 32'h0000_0008;
    assign o_irq_pending = {24'h0, i_raise[1], 3'h0, i_raise[0], 3'h0};
    // deep power-down is asked only by the rtc side
    assign o_rtc_dpd_req = i_dpd;
    assign o_rtc_alarm   = i_alarm;
    // reference tick every fourth clock
    always_ff @(posedge i_mclk)
    begin
        tick_cnt <= tick_cnt + 2'h1;
    end
    assign o_osc_ref_tick = (tick_cnt == 2'h3);
endmodule : cpm_far_side
`default_nettype wire

// file: verification/cpm_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cpm_top_tb;
    import cpm_pkg::*;
    logic        i_mclk = 1'b0, i_srst = 1'b1;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata, irq_en, irq_pd;
    logic [1:0]  raise = 2'h0;
    logic        dpd = 1'b0, alarm = 1'b0, rdy, slverr, tick, dpdq, alq;
    logic        core, per, rco, rcp, flp, flr, mulp, mulc, usbp, usbs;
    logic        usbc, chip, keep;
    logic [7:0]  cpud, usbd;
    logic [2:0]  probe;
    cpm_src_type src;
    cpm_out_type cko;
    int          fails = 0, checked = 0, n, hi = 0;
    assign probe = {chip, flr, core};
    // clock
    always #4 i_mclk = ~i_mclk;
    cpm_far_side far (.i_mclk(i_mclk), .i_raise(raise), .i_dpd(dpd),
        .i_alarm(alarm), .o_irq_enabled(irq_en), .o_irq_pending(irq_pd),
        .o_rtc_dpd_req(dpdq), .o_rtc_alarm(alq), .o_osc_ref_tick(tick));
    cpm_top dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(rdy),
        .o_pslverr(slverr), .i_irq_enabled(irq_en),
        .i_irq_pending(irq_pd), .i_rtc_dpd_req(dpdq), .i_rtc_alarm(alq),
        .i_osc_ref_tick(tick), .o_core_clk_en(core),
        .o_periph_clk_en(per), .o_rc_out_en(rco), .o_rc_power(rcp),
        .o_flash_power(flp), .o_flash_ready(flr), .o_mul_power(mulp),
        .o_mul_connect(mulc), .o_usb_mul_power(usbp),
        .o_usb_clk_from_usb_mul(usbs), .o_usb_clk(usbc), .o_src_sel(src),
        .o_clkout_sel(cko), .o_cpu_div(cpud), .o_usb_div(usbd),
        .o_rtc_keep(keep), .o_chip_power(chip));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        if (got !== exp)
            fails++;
    endtask : chk
    // one apb transfer, setup then access until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        pen <= 1'b1;
        do
            @(posedge i_mclk);
        while (rdy !== 1'b1);
        rd = prdata;
        err = slverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // wait a bounded time for one probe bit
    task wt(input int i, input logic v, input int lim);
        repeat (lim)
        begin
            if (probe[i] === v)
                break;
            @(posedge i_mclk);
        end
        chk(32'(probe[i]), 32'(v));
    endtask : wt
    task give_verdict;
        $display("mismatches %0d, checks %0d", fails, checked);
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // watchdog
    initial
    begin
        #400000;
        fails++;
        give_verdict;
    end
    // test sequence
    initial
    begin
        repeat (10) @(posedge i_mclk);
        i_srst <= 1'b0;
        chk(32'({mulp, mulc}), 32'h0);
        chk(32'({usbp, usbs}), 32'h0);
        chk(32'(src), 32'(SRC_RC));
        apb(1'b1, ADDR_CTRL, 32'h2);
        apb(1'b1, ADDR_DIV, 32'h0009_0018);
        chk(32'(mulc), 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        rd = 32'h0;
        for (n = 0; n < 1000 && rd[ST_LOCK] !== 1'b1; n++)
            apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'(rd[ST_LOCK]), 32'h1);
        apb(1'b1, ADDR_CLKDIV, 32'h0303);
        for (n = 0; n < 5; n++)
        begin
            apb(1'b1, ADDR_CTRL, 32'h7 | (32'(n) << CTRL_OUT_LO));
            repeat (2) @(posedge i_mclk);
            chk(32'(cko), 32'(n));
        end
        chk(32'({mulp, mulc, usbp, usbs}), 32'hF);
        for (n = 0; n < 8; n++)
        begin
            @(posedge i_mclk);
            hi += usbc;
        end
        chk(32'(hi), 32'h4);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        // sleep, then deep-sleep with a masked line first
        apb(1'b1, ADDR_PMODE, 32'h1);
        wt(0, 1'b0, 10);
        chk(32'(per), 32'h1);
        raise <= 2'h1;
        wt(0, 1'b1, 10);
        raise <= 2'h0;
        apb(1'b1, ADDR_PMODE, 32'h2);
        wt(0, 1'b0, 10);
        @(posedge i_mclk);
        chk({16'h0, cpud, usbd}, 32'h0);
        chk(32'(mulc), 32'h0);
        chk(32'({keep, rcp, rco, flp, per}), 32'h1A);
        raise <= 2'h2;
        repeat (300) @(posedge i_mclk);
        chk(32'(core), 32'h0);
        raise <= 2'h3;
        repeat (100) @(posedge i_mclk);
        chk(32'(core), 32'h0);
        wt(0, 1'b1, 100);
        raise <= 2'h0;
        // deep-sleep again, running from the main oscillator
        apb(1'b1, ADDR_CTRL, 32'h10);
        apb(1'b1, ADDR_PMODE, 32'h2);
        wt(0, 1'b0, 10);
        raise <= 2'h1;
        repeat (4000) @(posedge i_mclk);
        chk(32'(core), 32'h0);
        wt(0, 1'b1, 200);
        raise <= 2'h0;
        // power-down and its slow wake
        apb(1'b1, ADDR_PMODE, 32'h3);
        wt(0, 1'b0, 10);
        @(posedge i_mclk);
        chk(32'({rcp, flp, mulp, flr}), 32'h0);
        raise <= 2'h1;
        repeat (7000) @(posedge i_mclk);
        chk(32'(core), 32'h0);
        wt(0, 1'b1, 1000);
        raise <= 2'h0;
        chk(32'({flr, src}), 32'(SRC_RC));
        wt(1, 1'b1, 14000);
        dpd <= 1'b1;
        wt(2, 1'b0, 20);
        dpd <= 1'b0;
        alarm <= 1'b1;
        wt(2, 1'b1, 25000);
        give_verdict;
    end
endmodule : cpm_top_tb
`default_nettype wire
